/* File: ptpc_pkg.sv */
// Package for the precision-time clock block: register indices, field positions,
// reset values and timing constants.
// Assumes a 10 MHz system clock and an AHB-Lite slave with 32-bit data.
package ptpc_pkg;

    // ========================================================================
    // Register indices (byte address is four times the index)
    // ========================================================================
    localparam logic [10:0] IDX_CTRL = 11'h600;
    localparam logic [10:0] IDX_NSEC = 11'h604;
    localparam logic [10:0] IDX_SEC = 11'h608;
    localparam logic [10:0] IDX_PHASE = 11'h60C;
    localparam logic [10:0] IDX_RATE_LO = 11'h610;
    localparam logic [10:0] IDX_RATE_HI = 11'h612;
    localparam logic [10:0] IDX_DUR = 11'h614;
    localparam logic [10:0] IDX_TS_STAT = 11'h68C;
    localparam logic [10:0] IDX_TS_IEN = 11'h68E;
    localparam logic [10:0] IDX_EG_REQ = 11'h648;
    localparam logic [10:0] IDX_EG_SYNC = 11'h64C;
    localparam logic [10:0] IDX_EG_RESP = 11'h650;
    localparam logic [10:0] IDX_PORT_STRIDE = 11'h020;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int CTRL_STEP = 6;
    localparam int CTRL_STEP_DIR = 5;
    localparam int CTRL_READ = 4;
    localparam int CTRL_LOAD = 3;
    localparam int CTRL_CONT = 2;
    localparam int CTRL_ENABLE = 1;
    localparam int CTRL_RESET = 0;
    localparam int RATE_HI_DIR = 15;
    localparam int RATE_HI_TEMP = 14;
    localparam int TS_STAT_BASE = 12;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic CLK_EN_RST = 1'b1;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // ========================================================================
    // Timing constants
    // ========================================================================
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
    localparam int DUR_UNIT_NS = 40;
    // Duration is counted in half units so a 2.5 unit cycle stays exact.
    localparam logic [32:0] DUR_STEP_X2 = 33'(2 * CLK_PERIOD_NS / DUR_UNIT_NS);
    localparam logic [7:0] TICK_NS = 8'(CLK_PERIOD_NS);

    // Egress message types as presented by the transmit path.
    typedef enum logic [1:0] {
        PTPC_MSG_SYNC,
        PTPC_MSG_DELAY_REQ,
        PTPC_MSG_PDELAY_REQ,
        PTPC_MSG_PDELAY_RESP
    } ptpc_msg_e;

    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] ns;
    } ptpc_time_s;

endpackage : ptpc_pkg

/* File: ptpc_rtc.sv */
// Precision-time real time clock with step and rate adjustment, ingress
// timestamp formatting and per-port egress timestamp capture.
// Assumes it is the only AHB-Lite slave, so hreadyout is the bus hready.
//
// Functional notes
// - Step bit applies one correction, direction sets sign.
// - Continuous enable applies programmed rate correction.
// - Read bit captures time into ns/sec registers.
// - Load bit sets clock from ns/sec registers.
// - Step amount from nanosecond register; seconds change only on carry or borrow.
// - Phase is read-only three-bit code, 0 to 3.
// - Rate is 30 bits, low and high words.
// - Rate high bit 15 selects faster or slower.
// - Rate high bit 14 limits adjustment duration.
// - Duration is 32-bit count of 40 ns units.
// - Ingress timestamp produced for each PTP message.
// - Timestamp holds seconds[1:0] over nanoseconds.
// - Egress timestamp stored after each event message.
// - Sync, Pdelay_Resp own registers; requests share one.
// - Per-port egress register sets spaced 0x20 apart.
// - Newer message of same type overwrites timestamp.
// - Per-port egress status flags in bits 12 to 15.
// - Status forwarded as interrupt only when enabled.
`timescale 1ns/1ps
`default_nettype none

module ptpc_rtc #(
    parameter int NUM_PORTS = 2,
    parameter int AW = 13
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Ingress timestamp
    input wire logic rx_ptp_valid,
    output logic rx_ts_valid,
    output logic [31:0] rx_ts,
    // Egress events, one per port
    input wire logic [NUM_PORTS-1:0] tx_evt_valid,
    input wire logic [2*NUM_PORTS-1:0] tx_evt_type,
    // Egress timestamp interrupt
    output logic ts_irq
);

    localparam int SW = 2 * NUM_PORTS;

    // ========================================================================
    // Helper functions
    // ========================================================================
    function automatic ptpc_pkg::ptpc_time_s time_add(ptpc_pkg::ptpc_time_s t,
                                                      logic [31:0] d);
        logic [32:0] s;
        ptpc_pkg::ptpc_time_s r;
        s = {1'b0, t.ns} + {1'b0, d};
        r = t;
        if (s >= {1'b0, ptpc_pkg::NS_PER_SEC}) begin
            r.ns = 32'(s - {1'b0, ptpc_pkg::NS_PER_SEC});
            r.sec = t.sec + 32'h0000_0001;
        end else begin
            r.ns = s[31:0];
        end
        return r;
    endfunction : time_add

    function automatic ptpc_pkg::ptpc_time_s time_sub(ptpc_pkg::ptpc_time_s t,
                                                      logic [31:0] d);
        ptpc_pkg::ptpc_time_s r;
        r = t;
        if (t.ns >= d) begin
            r.ns = t.ns - d;
        end else begin
            r.ns = t.ns + ptpc_pkg::NS_PER_SEC - d;
            r.sec = t.sec - 32'h0000_0001;
        end
        return r;
    endfunction : time_sub

    function automatic logic [31:0] ts_fmt(ptpc_pkg::ptpc_time_s t);
        return {t.sec[1:0], t.ns[29:0]};
    endfunction : ts_fmt

    // ========================================================================
    // Bus front end
    // ========================================================================
    logic dp_wr_r;
    logic dp_rd_r;
    logic [10:0] dp_idx_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic [31:0] rd_mux;

    wire addr_ok = hsel & htrans[1] & hready;
    wire [10:0] a_idx = 11'(haddr[AW-1:2]);

    // Reads take one wait state so that hrdata comes from a flip-flop and
    // always reflects a write completed in the previous transfer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_idx_r <= 11'h000;
            hrdata_r <= ptpc_pkg::WORD_RST;
            hreadyout_r <= 1'b1;
        end else begin
            dp_wr_r <= addr_ok & hwrite;
            dp_rd_r <= addr_ok & ~hwrite;
            if (addr_ok) begin
                dp_idx_r <= a_idx;
            end
            hreadyout_r <= ~(addr_ok & ~hwrite);
            if (dp_rd_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;

    wire wr_ctrl = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_CTRL);
    wire wr_nsec = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_NSEC);
    wire wr_sec = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_SEC);
    wire wr_rlo = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_RATE_LO);
    wire wr_rhi = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_RATE_HI);
    wire wr_dur = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_DUR);
    wire wr_stat = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_TS_STAT);
    wire wr_ien = dp_wr_r & (dp_idx_r == ptpc_pkg::IDX_TS_IEN);

    // Command bits are one-shot: they act on the write and read back as zero.
    wire cmd_step = wr_ctrl & hwdata[ptpc_pkg::CTRL_STEP];
    wire cmd_read = wr_ctrl & hwdata[ptpc_pkg::CTRL_READ];
    wire cmd_load = wr_ctrl & hwdata[ptpc_pkg::CTRL_LOAD];
    wire cmd_reset = wr_ctrl & hwdata[ptpc_pkg::CTRL_RESET];

    // ========================================================================
    // Control and parameter registers
    // ========================================================================
    logic step_dir_r;
    logic cont_en_r;
    logic clk_en_r;
    logic [29:0] rate_r;
    logic rate_dir_r;
    logic temp_en_r;
    logic [31:0] dur_r;
    logic [SW-1:0] ts_ien_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_dir_r <= 1'b0;
            cont_en_r <= 1'b0;
            clk_en_r <= ptpc_pkg::CLK_EN_RST;
            rate_r <= 30'h0000_0000;
            rate_dir_r <= 1'b0;
            temp_en_r <= 1'b0;
            dur_r <= ptpc_pkg::WORD_RST;
            ts_ien_r <= '0;
        end else begin
            if (wr_ctrl) begin
                step_dir_r <= hwdata[ptpc_pkg::CTRL_STEP_DIR];
                cont_en_r <= hwdata[ptpc_pkg::CTRL_CONT];
                clk_en_r <= hwdata[ptpc_pkg::CTRL_ENABLE];
            end
            if (wr_rlo) begin
                rate_r[15:0] <= hwdata[15:0];
            end
            if (wr_rhi) begin
                rate_r[29:16] <= hwdata[13:0];
                rate_dir_r <= hwdata[ptpc_pkg::RATE_HI_DIR];
                temp_en_r <= hwdata[ptpc_pkg::RATE_HI_TEMP];
            end
            if (wr_dur) begin
                dur_r <= hwdata;
            end
            if (wr_ien) begin
                ts_ien_r <= hwdata[ptpc_pkg::TS_STAT_BASE +: SW];
            end
        end
    end

    // ========================================================================
    // Running clock
    // ========================================================================
    ptpc_pkg::ptpc_time_s now_r;
    ptpc_pkg::ptpc_time_s now_nxt;
    logic [31:0] frac_r;
    logic [32:0] temp_left_r;
    logic [31:0] nsec_reg_r;
    logic [31:0] sec_reg_r;
    logic [2:0] phase_cap_r;

    // The duration window is armed by writing the rate high word, so the
    // duration must be written first.
    wire adj_act = cont_en_r & (~temp_en_r | (temp_left_r != 33'h0_0000_0000));
    wire [32:0] frac_sum = {1'b0, frac_r} + {3'b000, rate_r};
    wire adj_carry = adj_act & frac_sum[32];
    wire [7:0] tick_inc = adj_carry ? (rate_dir_r ? ptpc_pkg::TICK_NS + 8'h01 :
                                                    ptpc_pkg::TICK_NS - 8'h01) :
                                      ptpc_pkg::TICK_NS;
    // Phase code follows the top two fraction bits in quarter-nanosecond steps, never past 3.
    wire [2:0] phase_now = {1'b0, frac_r[31:30]};
    ptpc_pkg::ptpc_time_s reg_time;
    assign reg_time = '{sec: sec_reg_r, ns: nsec_reg_r};

    always_comb begin
        now_nxt = now_r;
        if (cmd_reset) begin
            now_nxt = '0;
        end else if (cmd_load) begin
            now_nxt = reg_time;
        end else if (cmd_step) begin
            now_nxt = step_dir_r ? time_add(now_r, nsec_reg_r) :
                                   time_sub(now_r, nsec_reg_r);
        end else if (clk_en_r) begin
            now_nxt = time_add(now_r, {24'h00_0000, tick_inc});
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            now_r <= '0;
            frac_r <= ptpc_pkg::WORD_RST;
            temp_left_r <= 33'h0_0000_0000;
        end else begin
            now_r <= now_nxt;
            if (cmd_reset) begin
                frac_r <= ptpc_pkg::WORD_RST;
            end else if (clk_en_r && adj_act) begin
                frac_r <= frac_sum[31:0];
            end
            if (wr_rhi) begin
                temp_left_r <= {dur_r, 1'b0};
            end else if (temp_en_r && cont_en_r && clk_en_r) begin
                temp_left_r <= (temp_left_r > ptpc_pkg::DUR_STEP_X2) ?
                               temp_left_r - ptpc_pkg::DUR_STEP_X2 : 33'h0_0000_0000;
            end
        end
    end

    // Nanosecond and second registers: software value, or the captured time.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nsec_reg_r <= ptpc_pkg::WORD_RST;
            sec_reg_r <= ptpc_pkg::WORD_RST;
            phase_cap_r <= 3'h0;
        end else if (cmd_read) begin
            nsec_reg_r <= now_r.ns;
            sec_reg_r <= now_r.sec;
            phase_cap_r <= phase_now;
        end else begin
            if (wr_nsec) begin
                nsec_reg_r <= hwdata;
            end
            if (wr_sec) begin
                sec_reg_r <= hwdata;
            end
        end
    end

    // ========================================================================
    // Ingress timestamp
    // ========================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_ts_valid <= 1'b0;
            rx_ts <= ptpc_pkg::WORD_RST;
        end else begin
            rx_ts_valid <= rx_ptp_valid;
            if (rx_ptp_valid) begin
                rx_ts <= ts_fmt(now_r);
            end
        end
    end

    // ========================================================================
    // Egress timestamps and status
    // ========================================================================
    // Slot 0 requests, slot 1 Sync, slot 2 Pdelay_Resp, matching the map order.
    logic [31:0] eg_ts_r [NUM_PORTS][3];
    logic [SW-1:0] ts_stat_r;
    logic [SW-1:0] stat_set;
    logic [1:0] eg_slot [NUM_PORTS];

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            unique case (ptpc_pkg::ptpc_msg_e'(tx_evt_type[2*p +: 2]))
                ptpc_pkg::PTPC_MSG_SYNC: eg_slot[p] = 2'd1;
                ptpc_pkg::PTPC_MSG_PDELAY_RESP: eg_slot[p] = 2'd2;
                ptpc_pkg::PTPC_MSG_DELAY_REQ,
                ptpc_pkg::PTPC_MSG_PDELAY_REQ: eg_slot[p] = 2'd0;
            endcase
            stat_set[2*p] = tx_evt_valid[p] & (eg_slot[p] == 2'd1);
            stat_set[2*p+1] = tx_evt_valid[p] & (eg_slot[p] != 2'd1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int s = 0; s < 3; s++) begin
                    eg_ts_r[p][s] <= ptpc_pkg::WORD_RST;
                end
            end
            ts_stat_r <= '0;
            ts_irq <= 1'b0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (tx_evt_valid[p]) begin
                    eg_ts_r[p][eg_slot[p]] <= ts_fmt(now_r);
                end
            end
            // Write one to clear; a new event in the same cycle keeps its flag.
            ts_stat_r <= (ts_stat_r & ~(wr_stat ? hwdata[ptpc_pkg::TS_STAT_BASE +: SW] :
                                        {SW{1'b0}})) | stat_set;
            ts_irq <= |(ts_stat_r & ts_ien_r);
        end
    end

    // ========================================================================
    // Read multiplexer
    // ========================================================================
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (dp_idx_r)
            ptpc_pkg::IDX_CTRL: rd_mux = {25'h000_0000, 1'b0, step_dir_r, 2'b00,
                                          cont_en_r, clk_en_r, 1'b0};
            ptpc_pkg::IDX_NSEC: rd_mux = nsec_reg_r;
            ptpc_pkg::IDX_SEC: rd_mux = sec_reg_r;
            ptpc_pkg::IDX_PHASE: rd_mux = {29'h0000_0000, phase_cap_r};
            ptpc_pkg::IDX_RATE_LO: rd_mux = {16'h0000, rate_r[15:0]};
            ptpc_pkg::IDX_RATE_HI: rd_mux = {16'h0000, rate_dir_r, temp_en_r, rate_r[29:16]};
            ptpc_pkg::IDX_DUR: rd_mux = dur_r;
            ptpc_pkg::IDX_TS_STAT: rd_mux = 32'(ts_stat_r) << ptpc_pkg::TS_STAT_BASE;
            ptpc_pkg::IDX_TS_IEN: rd_mux = 32'(ts_ien_r) << ptpc_pkg::TS_STAT_BASE;
            default: begin
                for (int p = 0; p < NUM_PORTS; p++) begin
                    if (dp_idx_r == ptpc_pkg::IDX_EG_REQ + 11'(p) * ptpc_pkg::IDX_PORT_STRIDE) begin
                        rd_mux = eg_ts_r[p][0];
                    end
                    if (dp_idx_r == ptpc_pkg::IDX_EG_SYNC + 11'(p) * ptpc_pkg::IDX_PORT_STRIDE) begin
                        rd_mux = eg_ts_r[p][1];
                    end
                    if (dp_idx_r == ptpc_pkg::IDX_EG_RESP + 11'(p) * ptpc_pkg::IDX_PORT_STRIDE) begin
                        rd_mux = eg_ts_r[p][2];
                    end
                end
            end
        endcase
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_addr;
        addr_ok && !hwrite;
    endsequence

    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait_state: assert property (s_rd_addr |=> s_rd_answer)
        else $error("read answer not one wait state");
    a_step_add_ns: assert property (cmd_step && step_dir_r && !cmd_reset && !cmd_load |=>
        now_r == time_add($past(now_r), $past(nsec_reg_r)))
        else $error("step add wrong");
    a_step_keep_sec: assert property (cmd_step && !cmd_reset && !cmd_load &&
        nsec_reg_r < now_r.ns && !step_dir_r |=> now_r.sec == $past(now_r.sec))
        else $error("step altered seconds");
    a_load_clock: assert property (cmd_load && !cmd_reset |=> now_r == $past(reg_time))
        else $error("load did not set clock");
    a_read_capture: assert property (cmd_read |=> nsec_reg_r == $past(now_r.ns)
        && sec_reg_r == $past(now_r.sec))
        else $error("read did not capture time");
    a_ns_in_range: assert property (now_r.ns < ptpc_pkg::NS_PER_SEC)
        else $error("nanoseconds out of range");
    a_phase_legal: assert property (phase_cap_r <= 3'h4)
        else $error("illegal phase code");
    a_clock_stopped: assert property (!clk_en_r && !wr_ctrl |=> $stable(now_r))
        else $error("clock moved while disabled");
    a_reset_zero: assert property (cmd_reset |=> now_r == '0 ##1 now_r.sec == 32'h0000_0000)
        else $error("clock reset failed");
    a_rate_faster: assert property (clk_en_r && adj_carry && rate_dir_r && !wr_ctrl
        |-> tick_inc == ptpc_pkg::TICK_NS + 8'h01)
        else $error("faster rate wrong");
    a_temp_expired: assert property (temp_en_r && temp_left_r == 33'h0_0000_0000
        |-> !adj_act)
        else $error("temporary adjustment overran");
    a_egress_sync: assert property (tx_evt_valid[0] &&
        tx_evt_type[1:0] == 2'(ptpc_pkg::PTPC_MSG_SYNC)
        |=> eg_ts_r[0][1] == ts_fmt($past(now_r)) && ts_stat_r[0])
        else $error("sync egress not captured");
    a_ingress_fmt: assert property (rx_ptp_valid |=> rx_ts_valid &&
        rx_ts[31:30] == $past(now_r.sec[1:0]))
        else $error("ingress timestamp format");
    a_irq_gated: assert property (ts_irq |-> |($past(ts_stat_r) & $past(ts_ien_r)))
        else $error("interrupt without enabled status");

endmodule : ptpc_rtc

`default_nettype wire

/* File: tb_ptp_clock_adjust_timestamp.sv */
// Self-checking bench for the precision-time clock block.
// Assumes the block is the only AHB-Lite slave, so its hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module tb_ptp_clock_adjust_timestamp;
    logic hclk, hresetn, hsel, hwrite, rx_ptp_valid, hreadyout, hresp, rx_ts_valid, ts_irq;
    logic [12:0] haddr;
    logic [1:0] htrans, tx_evt_valid;
    logic [2:0] hsize;
    logic [3:0] tx_evt_type;
    logic [31:0] hwdata, hrdata, rx_ts, rd;
    int err_count = 0;
    int num_checks = 0;
    ptpc_rtc i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_ptp_valid(rx_ptp_valid), .rx_ts_valid(rx_ts_valid), .rx_ts(rx_ts),
        .tx_evt_valid(tx_evt_valid), .tx_evt_type(tx_evt_type), .ts_irq(ts_irq));
    // ========================================================================
    // Bus and compare tasks
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // The address phase is held until hready is seen high, then the data phase.
    task automatic bus(input logic wr, input logic [10:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [10:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask : wr
    task automatic rc(input logic [10:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask : rc
    // Load ends on the last edge of the control write, so time is known there.
    task automatic load(input logic [31:0] ns, input logic [31:0] sec);
        wr(ptpc_pkg::IDX_NSEC, ns);
        wr(ptpc_pkg::IDX_SEC, sec);
        wr(ptpc_pkg::IDX_CTRL, 32'h0000_000A);
    endtask : load
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // ========================================================================
    // Clock, reset, watchdog
    // ========================================================================
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        #2_000_000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
    // ========================================================================
    // Tests
    // ========================================================================
    initial begin
        {hresetn, hsel, hwrite, rx_ptp_valid, haddr, htrans, tx_evt_valid} = '0;
        {tx_evt_type, hwdata} = '0;
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rc(ptpc_pkg::IDX_CTRL, 32'h0000_0002);
        rc(ptpc_pkg::IDX_DUR, 32'h0000_0000);
        rc(ptpc_pkg::IDX_EG_SYNC, 32'h0000_0000);
        wr(11'h7F0, 32'h1234_5678);
        rc(11'h7F0, 32'h0000_0000);
        wr(ptpc_pkg::IDX_RATE_LO, 32'h0000_ABCD);
        wr(ptpc_pkg::IDX_RATE_HI, 32'h0000_C123);
        rc(ptpc_pkg::IDX_RATE_LO, 32'h0000_ABCD);
        rc(ptpc_pkg::IDX_RATE_HI, 32'h0000_C123);
        wr(ptpc_pkg::IDX_DUR, 32'h0000_0019);
        rc(ptpc_pkg::IDX_DUR, 32'h0000_0019);
        chk({31'h0, hresp}, 32'h0000_0000);
        $display("register test done");
        // One tick of 100 ns lands between load and the read capture.
        load(32'h0000_03E8, 32'h0000_0005);
        wr(ptpc_pkg::IDX_CTRL, 32'h0000_0012);
        rc(ptpc_pkg::IDX_NSEC, 32'h0000_044C);
        rc(ptpc_pkg::IDX_SEC, 32'h0000_0005);
        rc(ptpc_pkg::IDX_PHASE, 32'h0000_0000);
        $display("load and read test done");
        // Subtracting 500 ns at 1300 ns must not borrow from seconds.
        load(32'h0000_03E8, 32'h0000_0007);
        wr(ptpc_pkg::IDX_NSEC, 32'h0000_01F4);
        wr(ptpc_pkg::IDX_CTRL, 32'h0000_0042);
        wr(ptpc_pkg::IDX_CTRL, 32'h0000_0012);
        rc(ptpc_pkg::IDX_NSEC, 32'h0000_0384);
        rc(ptpc_pkg::IDX_SEC, 32'h0000_0007);
        rc(ptpc_pkg::IDX_NSEC, 32'h0000_0384);
        $display("step test done");
        // Ingress and both egress ports in the cycle after a load.
        load(32'h0000_03E8, 32'h0000_0007);
        rx_ptp_valid <= 1'b1;
        tx_evt_valid <= 2'b11;
        tx_evt_type <= 4'b1110;
        @(posedge hclk);
        rx_ptp_valid <= 1'b0;
        tx_evt_valid <= 2'b00;
        #1;
        chk({31'h0, rx_ts_valid}, 32'h0000_0001);
        chk(rx_ts, 32'hC000_03E8);
        // A Sync on port 0 one cycle later sees the clock at 1100 ns.
        tx_evt_valid <= 2'b01;
        tx_evt_type <= 4'b0000;
        @(posedge hclk);
        tx_evt_valid <= 2'b00;
        rc(ptpc_pkg::IDX_EG_REQ, 32'hC000_03E8);
        rc(ptpc_pkg::IDX_EG_RESP + ptpc_pkg::IDX_PORT_STRIDE, 32'hC000_03E8);
        rc(ptpc_pkg::IDX_EG_SYNC, 32'hC000_044C);
        rc(ptpc_pkg::IDX_TS_STAT, 32'h0000_B000);
        chk({31'h0, ts_irq}, 32'h0000_0000);
        wr(ptpc_pkg::IDX_TS_IEN, 32'h0000_2000);
        @(posedge hclk);
        #1;
        chk({31'h0, ts_irq}, 32'h0000_0001);
        wr(ptpc_pkg::IDX_TS_STAT, 32'h0000_2000);
        rc(ptpc_pkg::IDX_TS_STAT, 32'h0000_9000);
        chk({31'h0, ts_irq}, 32'h0000_0000);
        $display("timestamp test done");
        // Full-scale faster rate carries on the fifth adjusted tick: 701 ns, phase 2.
        wr(ptpc_pkg::IDX_RATE_LO, 32'h0000_FFFF);
        wr(ptpc_pkg::IDX_RATE_HI, 32'h0000_BFFF);
        wr(ptpc_pkg::IDX_NSEC, 32'h0000_0000);
        wr(ptpc_pkg::IDX_SEC, 32'h0000_0000);
        wr(ptpc_pkg::IDX_CTRL, 32'h0000_000E);
        repeat (6) @(posedge hclk);
        wr(ptpc_pkg::IDX_CTRL, 32'h0000_0016);
        rc(ptpc_pkg::IDX_NSEC, 32'h0000_02BD);
        rc(ptpc_pkg::IDX_PHASE, 32'h0000_0002);
        $display("rate test done");
        complete_run();
    end
endmodule : tb_ptp_clock_adjust_timestamp
`default_nettype wire
